//--- rtl/ifd_regs.svh
// Purpose: Constants for the instruction field decoder and address unit
// Assumes: 36-bit words, bit 0 is the most significant
// Notes: Bit numbers below are LSB-based vector indices
`ifndef IFD_REGS_SVH
`define IFD_REGS_SVH
`define IFD_OP_HI 35
`define IFD_OP_LO 27
`define IFD_AC_HI 26
`define IFD_AC_LO 23
`define IFD_IND_BIT 22
`define IFD_X_HI 21
`define IFD_X_LO 18
`define IFD_Y_HI 17
`define IFD_Y_LO 0
`define IFD_IO_HI 35
`define IFD_IO_LO 33
`define IFD_DEV_HI 32
`define IFD_DEV_LO 26
`define IFD_IOOP_HI 25
`define IFD_IOOP_LO 23
`define IFD_XOP_HI 35
`define IFD_XOP_LO 23
`define IFD_EXTEND_OP 9'h053
`define IFD_IO_MARK 3'h7
`define IFD_FAST_TOP 18'h0000F
`define IFD_WORD_ZERO 36'h000000000
`define IFD_HALF_ZERO 18'h00000
`endif

//--- rtl/ifd_pkg.sv
// Purpose: Types shared by the decoder and its partners
// Assumes: Constants come from ifd_regs.svh
// Notes: Types only
package ifd_pkg;
	typedef logic [35:0] ifd_word_t;
	typedef logic [17:0] ifd_half_t;
	typedef struct packed {
		logic [8:0] opcode;
		logic [3:0] ac;
		logic indirect;
		logic [3:0] index_sel;
		logic [17:0] addr;
	} ifd_fields_s;
	typedef struct packed {
		logic io_instr;
		logic [6:0] device;
		logic [2:0] io_op;
		logic [12:0] wide_op;
		logic [3:0] flags;
	} ifd_variant_s;
	typedef struct packed {
		logic [17:0] ea;
		logic [17:0] imm;
		logic fast_mem;
		logic extended;
		logic [8:0] ext_op;
		logic trap;
	} ifd_result_s;
endpackage : ifd_pkg

//--- rtl/ifd_decode_ea.sv
// Purpose: Instruction field decode and effective address calculation
// Assumes: Single section, 18-bit addressing; memory answers with a one-cycle valid
// Notes: Pager off, all addresses physical
`timescale 1ns/1ps
`default_nettype none
`include "ifd_regs.svh"

// How it works
// - opcode top nine bits, accumulator next four
// - bit 13 indirect, 14-17 index, 18-35 address
// - variants: flag bits or thirteen-bit opcode
// - unassigned opcode traps as monitor operation
// - three leading ones mark old IO
// - old IO: device 3-9, op 10-12
// - no indirect, no index: address unchanged
// - index right half added to address
// - indirect chains fetch until flag clear
// - arithmetic wraps within eighteen bits
// - address computed for every instruction
// - indirect flag means indirect address always
// - immediate mode uses result as operand
// - address done before any other action
// - unlabeled read bits return zero
// - extend opcode fetches second word at result
// - second word gets its own address
// - unassigned extended codes trap as monitor
// - paging off, addresses used physically
// - fast memory addresses skip translation
module ifd_decode_ea
	import ifd_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESET_N_I,
	// Instruction issue
	input wire logic START_I,
	input wire ifd_word_t INSTR_I,
	output logic BUSY_O,
	// Opcode legality from execute stage tables
	input wire logic OP_ASSIGNED_I,
	input wire logic XOP_ASSIGNED_I,
	// Index register file
	output logic [3:0] INDEX_SEL_O,
	input wire ifd_half_t INDEX_RH_I,
	// Memory fetch path
	output logic MEM_REQ_O,
	output ifd_half_t MEM_ADDR_O,
	input wire logic MEM_VALID_I,
	input wire ifd_word_t MEM_DATA_I,
	// Execute stage
	output logic DONE_O,
	output ifd_fields_s FIELDS_O,
	output ifd_variant_s VARIANT_O,
	output ifd_result_s RESULT_O,
	output ifd_half_t VMA_O
);

	// ************************************************************
	// Decode helpers
	// ************************************************************
	function automatic ifd_fields_s split_word(input ifd_word_t w);
		ifd_fields_s f;
		f.opcode = w[`IFD_OP_HI:`IFD_OP_LO];
		f.ac = w[`IFD_AC_HI:`IFD_AC_LO];
		f.indirect = w[`IFD_IND_BIT];
		f.index_sel = w[`IFD_X_HI:`IFD_X_LO];
		f.addr = w[`IFD_Y_HI:`IFD_Y_LO];
		return f;
	endfunction : split_word

	// Carry out of bit 18 is simply dropped
	function automatic ifd_half_t add_half(input ifd_half_t a, input ifd_half_t b);
		logic [18:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[17:0];
	endfunction : add_half

	typedef enum logic [2:0] {S_IDLE, S_INDEX, S_FETCH, S_WAIT, S_EXT, S_DONE} ifd_state_e;

	ifd_state_e state_r;
	ifd_word_t instr_r;
	ifd_word_t addr_word_r;
	logic second_r;
	logic [3:0] xsel_r;
	ifd_half_t ea_r;
	ifd_half_t mod_addr;
	ifd_fields_s aw;

	assign aw = split_word(addr_word_r);
	// Index 0 contributes nothing
	assign mod_addr = (aw.index_sel == 4'h0) ? aw.addr :
		add_half(aw.addr, INDEX_RH_I);

	// ************************************************************
	// Address sequencer
	// ************************************************************
	// Instruction word is latched at start and reloaded only with the second word of an extend; later INSTR_I values cannot reach it
	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			state_r <= S_IDLE;
			instr_r <= `IFD_WORD_ZERO;
			addr_word_r <= `IFD_WORD_ZERO;
			second_r <= 1'b0;
			ea_r <= `IFD_HALF_ZERO;
		end else begin
			unique case (state_r)
				S_IDLE: begin
					if (START_I) begin
						instr_r <= INSTR_I;
						addr_word_r <= INSTR_I;
						second_r <= 1'b0;
						state_r <= S_INDEX;
					end
				end
				S_INDEX: begin
					ea_r <= mod_addr;
					if (aw.indirect) begin
						state_r <= S_FETCH;
					end else begin
						state_r <= S_EXT;
					end
				end
				S_FETCH: begin
					state_r <= S_WAIT;
				end
				S_WAIT: begin
					if (MEM_VALID_I) begin
						addr_word_r <= MEM_DATA_I;
						state_r <= S_INDEX;
					end
				end
				S_EXT: begin
					// First-word result addresses the second word
					if (!second_r && split_word(instr_r).opcode == `IFD_EXTEND_OP) begin
						second_r <= 1'b1;
						state_r <= S_FETCH;
					end else begin
						state_r <= S_DONE;
					end
				end
				S_DONE: begin
					state_r <= S_IDLE;
				end
			endcase
			// Second word arrives: decode it and compute its own address
			if (state_r == S_WAIT && MEM_VALID_I && second_r && !aw.indirect) begin
				instr_r <= MEM_DATA_I;
			end
		end
	end

	// Accumulator of the first word is kept for extended forms
	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			xsel_r <= 4'h0;
		end else if (START_I && state_r == S_IDLE) begin
			xsel_r <= INSTR_I[`IFD_AC_HI:`IFD_AC_LO];
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	ifd_fields_s f1;
	ifd_word_t sec_word;
	logic is_ext;
	assign is_ext = second_r;
	assign sec_word = instr_r;
	assign f1 = split_word(instr_r);

	assign BUSY_O = (state_r != S_IDLE);
	assign INDEX_SEL_O = aw.index_sel;
	assign MEM_REQ_O = (state_r == S_FETCH);
	// Pager off: computed address goes out as physical
	assign MEM_ADDR_O = ea_r;
	assign VMA_O = ea_r;
	assign DONE_O = (state_r == S_DONE);

	// After the second fetch instr_r holds the whole second word; AC stays in xsel_r
	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			FIELDS_O <= '0;
			VARIANT_O <= '0;
			RESULT_O <= '0;
		end else if (state_r == S_EXT && !(!second_r && f1.opcode == `IFD_EXTEND_OP)) begin
			FIELDS_O <= '{opcode: f1.opcode, ac: is_ext ? xsel_r : f1.ac,
				indirect: f1.indirect, index_sel: f1.index_sel, addr: f1.addr};
			VARIANT_O.io_instr <= (sec_word[`IFD_IO_HI:`IFD_IO_LO] == `IFD_IO_MARK) && !is_ext;
			VARIANT_O.device <= sec_word[`IFD_DEV_HI:`IFD_DEV_LO];
			VARIANT_O.io_op <= sec_word[`IFD_IOOP_HI:`IFD_IOOP_LO];
			VARIANT_O.wide_op <= sec_word[`IFD_XOP_HI:`IFD_XOP_LO];
			VARIANT_O.flags <= sec_word[`IFD_AC_HI:`IFD_AC_LO];
			RESULT_O.ea <= ea_r;
			RESULT_O.imm <= ea_r;
			// Fast memory bypasses translation straight from the address register
			RESULT_O.fast_mem <= (ea_r <= `IFD_FAST_TOP);
			RESULT_O.extended <= is_ext;
			// Unlabeled result bits stay zero
			RESULT_O.ext_op <= is_ext ? f1.opcode : 9'h000;
			RESULT_O.trap <= is_ext ? !XOP_ASSIGNED_I : !OP_ASSIGNED_I;
		end
	end

endmodule : ifd_decode_ea
`default_nettype wire

//--- dv/ifd_checker.sv
// Purpose: Port assertions for the decoder
// Assumes: Bound to ifd_decode_ea
// Notes: Instruction captured at take
`timescale 1ns/1ps
`default_nettype none
module ifd_checker
	import ifd_pkg::*;
(
	// Watched ports
	input wire logic CORE_CLK_I,
	input wire logic RESET_N_I,
	input wire logic START_I,
	input wire ifd_word_t INSTR_I,
	input wire logic BUSY_O,
	input wire logic OP_ASSIGNED_I,
	input wire logic MEM_REQ_O,
	input wire logic DONE_O,
	input wire ifd_fields_s FIELDS_O,
	input wire ifd_variant_s VARIANT_O,
	input wire ifd_result_s RESULT_O
);
	ifd_word_t iw_r;
	logic pl;
	assign pl = DONE_O && !RESULT_O.extended;
	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I)
			iw_r <= '0;
		else if (START_I && !BUSY_O)
			iw_r <= INSTR_I;
	end
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	sequence s_take_direct;
		START_I && !BUSY_O && !INSTR_I[22] && INSTR_I[35:27] != 9'h053;
	endsequence
	a_done_pulse:
	assert property (DONE_O |=> !DONE_O) else $error("done too long");
	a_fields_split:
	assert property (pl |-> FIELDS_O == iw_r) else $error("fields wrong");
	a_io_format:
	assert property (pl |-> VARIANT_O.io_instr == (iw_r[35:33] == 3'h7)
		&& VARIANT_O.device == iw_r[32:26] && VARIANT_O.io_op == iw_r[25:23])
		else $error("io fields wrong");
	a_direct_ea:
	assert property (pl && iw_r[22:18] == 5'h00 |-> RESULT_O.ea == iw_r[17:0])
		else $error("direct ea wrong");
	a_imm_equal:
	assert property (DONE_O |-> RESULT_O.imm == RESULT_O.ea) else $error("imm wrong");
	a_fast_range:
	assert property (DONE_O |-> RESULT_O.fast_mem == (RESULT_O.ea <= 18'h0000F))
		else $error("fast flag wrong");
	a_direct_time:
	assert property (s_take_direct |-> ##1 (!MEM_REQ_O && !DONE_O)[*2] ##1 DONE_O)
		else $error("direct timing wrong");
	a_trap_source:
	assert property (pl |-> RESULT_O.trap == !$past(OP_ASSIGNED_I)) else $error("trap wrong");
endmodule : ifd_checker
`default_nettype wire

//--- dv/ifd_far_model.sv
// Purpose: Memory and index file beside the decoder
// Assumes: Addresses alias modulo 256
// Notes: Data inverts between answers
`timescale 1ns/1ps
`default_nettype none
module ifd_far_model
	import ifd_pkg::*;
(
	// Inputs
	input wire logic clk_i,
	input wire logic [3:0] sel_i,
	input wire logic req_i,
	input wire ifd_half_t addr_i,
	input wire logic [1:0] lat_i,
	// Outputs
	output ifd_half_t rh_o,
	output var logic valid_o = 1'b0,
	output var ifd_word_t data_o = '0
);
	ifd_word_t mem [256];
	ifd_half_t xr [16];
	ifd_half_t addr_r = '0;
	logic [2:0] cnt_r = 3'h0;
	assign rh_o = xr[sel_i];
	always @(posedge clk_i) begin
		valid_o <= cnt_r == 3'h1;
		// Stale data flips to its complement every cycle
		data_o <= cnt_r == 3'h1 ? mem[addr_r[7:0]] : ~data_o;
		if (req_i) begin
			addr_r <= addr_i;
			cnt_r <= {1'b0, lat_i} + 3'h1;
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
		end
	end
endmodule : ifd_far_model
`default_nettype wire

//--- dv/test_ifd_decode_ea.sv
// Purpose: Self-checking bench for the decoder
// Assumes: Far model serves fetches
// Notes: Model ea computed with integers
`timescale 1ns/1ps
`default_nettype none
module test_ifd_decode_ea
	import ifd_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, op_ok = 1'b0, xop_ok = 1'b0;
	logic [1:0] lat = 2'h0;
	ifd_word_t instr = '0, data;
	logic busy, req, valid, done;
	logic [3:0] sel;
	ifd_half_t rh, addr, virtual_memory_address_reg;
	ifd_fields_s fld;
	ifd_variant_s vrn;
	ifd_result_s res;
	int failures = 0, checks = 0;
	logic [15:0] rng = 16'h0010;
	always #25 clk = ~clk;
	ifd_decode_ea DUT (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .START_I(start), .INSTR_I(instr),
		.BUSY_O(busy), .OP_ASSIGNED_I(op_ok), .XOP_ASSIGNED_I(xop_ok), .INDEX_SEL_O(sel),
		.INDEX_RH_I(rh), .MEM_REQ_O(req), .MEM_ADDR_O(addr), .MEM_VALID_I(valid),
		.MEM_DATA_I(data), .DONE_O(done), .FIELDS_O(fld), .VARIANT_O(vrn), .RESULT_O(res),
		.VMA_O(virtual_memory_address_reg));
	ifd_far_model far (.clk_i(clk), .sel_i(sel), .req_i(req), .addr_i(addr), .lat_i(lat),
		.rh_o(rh), .valid_o(valid), .data_o(data));
	function automatic ifd_word_t rw();
		repeat (3) rng = {rng[14:0], rng[15] ^ rng[13] ^ rng[12] ^ rng[10]};
		return {rng, rng[3:0], rng};
	endfunction : rw
	function automatic int ea(ifd_word_t w);
		int e;
		repeat (8) begin
			e = (w[17:0] + (w[21:18] != 4'h0 ? far.xr[w[21:18]] : 0)) % 262144;
			if (!w[22]) return e;
			w = far.mem[e % 256];
		end
		return -1;
	endfunction : ea
	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			failures++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	initial begin
		ifd_word_t w, w2;
		int e, n;
		logic x;
		for (int i = 0; i < 256; i++) begin
			w = rw();
			w[26:22] = {4'h0, i < 64};
			// Two-level chains that always end
			if (i < 64) w[21:0] = {4'h0, 18'(i + 32)};
			far.mem[i] = w;
			far.xr[i % 16] = w[17:0];
		end
		far.xr[1] = 18'h3FFFF;
		repeat (5) @(posedge clk);
		chk(res === '0 && done === 1'b0 && req === 1'b0 && busy === 1'b0, "reset state");
		rst_n <= 1'b1;
		for (int k = 0; k < 300; k++) begin
			w = rw();
			if (k % 4 == 0) w[35:27] = 9'h053;
			if (k % 5 == 0) w[22:18] = 5'h00;
			x = w[35:27] == 9'h053;
			@(posedge clk);
			start <= 1'b1;
			instr <= w;
			op_ok <= rng[3];
			xop_ok <= rng[5];
			lat <= rng[1:0];
			@(posedge clk);
			// Junk held up while busy must be ignored
			instr <= ~w;
			@(posedge clk);
			start <= 1'b0;
			n = 0;
			do @(negedge clk); while (done !== 1'b1 && ++n < 200);
			e = ea(w);
			if (x) begin
				w2 = far.mem[e % 256];
				chk(res.ext_op === w2[35:27], "ext op");
				e = ea(w2);
			end
			chk(n < 200 && res.ea === 18'(e), "ea");
			chk(res.extended === x, "extend");
			chk(virtual_memory_address_reg === 18'(e), "vma");
			chk(res.trap === ~(x ? xop_ok : op_ok), "trap");
			chk(res.fast_mem === (e < 16), "fast");
			if (!x) chk(vrn.wide_op === w[35:23] && vrn.flags === w[26:23], "wide");
		end
		print_verdict();
	end
	initial begin
		#2000000;
		failures++;
		print_verdict();
	end
endmodule : test_ifd_decode_ea
bind ifd_decode_ea ifd_checker chk_u (.CORE_CLK_I, .RESET_N_I, .START_I, .INSTR_I, .BUSY_O,
	.OP_ASSIGNED_I, .MEM_REQ_O, .DONE_O, .FIELDS_O, .VARIANT_O, .RESULT_O);
`default_nettype wire
